// File: design/isem_pkg.sv
// constants shared by the interrupt source enable masking stage
//
// Notes on behaviour
// - enable bit 1 passes source; reset clears all
// - main bits 31/30 gate sub fast requests
// - main bits 1/0 gate sub normal requests
// - main bit 3 gates timer4 or motor pwm
// - sub1 bit 24 gates software trigger bit 0
// - sub1 bits 26, 19, 18 are active low
// - main bits 29/28/27: ethernet, dma, milli timer
// - main bits 15/13 card, 14 panel, 11 nand
// - main bits 6/5/4: watchdog, fast timer, timer5
// - sub1 bits 31..25 gate the usb sources
// - sub1 bits 17/14/13 gate pll lock sources
// - sub1 bits 8/7/6 gate touch screen sources
// - sub1 bits 2/1 gate debug channel sources
// - sub1 bits 20/22/23/12/4 gate listed sources
// - raw status unmasked; masked status and requests gated
// - peripheral clock; registers on peripheral bus
package isem_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [31:0] MAIN_ENABLE_ADDR = 32'h4000_8000;
  localparam logic [31:0] SUB1_ENABLE_ADDR = 32'h4000_C000;
  localparam logic [31:0] ENABLE_RESET     = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_READ    = 32'h0000_0000;

  // ----------------------------------------------------------------
  // main controller bit positions
  // ----------------------------------------------------------------
  localparam int MAIN_SUB2_FAST_BIT   = 31;
  localparam int MAIN_SUB1_FAST_BIT   = 30;
  localparam int MAIN_TIMER4_BIT      = 3;
  localparam int MAIN_SUB2_NORMAL_BIT = 1;
  localparam int MAIN_SUB1_NORMAL_BIT = 0;
  localparam int MAIN_ETHERNET_BIT    = 29;

  // positions driven inside the block rather than by main_src_in
  localparam logic [31:0] MAIN_OWNED_MASK = 32'hC000_000B;

  // ----------------------------------------------------------------
  // first sub controller bit positions
  // ----------------------------------------------------------------
  localparam int SUB1_USB_I2C_BIT   = 31;
  localparam int SUB1_USB_ATX_BIT   = 26;
  localparam int SUB1_SOFT_IRQ_BIT  = 24;
  localparam int SUB1_I2C1_BIT      = 19;
  localparam int SUB1_I2C2_BIT      = 18;
  localparam int SOFT_TRIGGER_BIT   = 0;
  localparam int TIMER_CTRL_PWM_BIT = 6;

  // inputs that signal a request by going low
  localparam logic [31:0] SUB1_ACTIVE_LOW_MASK = 32'h040C_0000;

endpackage : isem_pkg

// File: design/isem_mask_stage.sv
// one 32-source enable register with its masking and request outputs
`timescale 1ns/1ps
module isem_mask_stage (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // enable register write
  input  wire logic        wr_en,
  input  wire logic [31:0] wr_data,
  // sources, already active high, and fast steering
  input  wire logic [31:0] src_active,
  input  wire logic [31:0] fast_sel,
  // state and requests
  output logic      [31:0] enable_reg,
  output logic      [31:0] masked_reg,
  output logic             normal_req_n,
  output logic             fast_req_n
);

  logic [31:0] enable_next;
  logic [31:0] masked_next;
  logic        normal_next_n;
  logic        fast_next_n;

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  // all 32 bits are stored so every position reads back as written
  assign enable_next   = wr_en ? wr_data : enable_reg;
  // a set bit passes its source, a clear bit blocks it
  assign masked_next   = src_active & enable_reg;
  assign normal_next_n = ~|(masked_next & ~fast_sel);
  assign fast_next_n   = ~|(masked_next & fast_sel);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // masking is recomputed every clock, so no stored event is touched
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      enable_reg   <= isem_pkg::ENABLE_RESET;
      masked_reg   <= 32'h0000_0000;
      normal_req_n <= 1'b1;
      fast_req_n   <= 1'b1;
    end else begin
      enable_reg   <= enable_next;
      masked_reg   <= masked_next;
      normal_req_n <= normal_next_n;
      fast_req_n   <= fast_next_n;
    end
  end

endmodule : isem_mask_stage

// File: design/isem_top.sv
// main and first sub controller enable masking with register access
`timescale 1ns/1ps
module isem_top (
  // peripheral clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // register access
  input  wire logic [31:0] bus_addr,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [31:0] bus_wdata,
  output logic      [31:0] bus_rdata,
  output logic             bus_rvalid,
  // main controller sources
  input  wire logic [31:0] main_src_in,
  input  wire logic        timer4_irq,
  input  wire logic        motor_pwm_irq,
  input  wire logic        timer_clock_ctrl_pwm_sel,
  input  wire logic        sub2_normal_req_n,
  input  wire logic        sub2_fast_req_n,
  input  wire logic [31:0] main_fast_sel,
  // first sub controller sources
  input  wire logic [31:0] sub1_src_in,
  input  wire logic [7:0]  soft_irq_trigger,
  input  wire logic [31:0] sub1_fast_sel,
  // status
  output logic      [31:0] main_raw_status,
  output logic      [31:0] main_masked_status,
  output logic      [31:0] sub1_raw_status,
  output logic      [31:0] sub1_masked_status,
  output logic             sub1_normal_req_n,
  output logic             sub1_fast_req_n,
  // processor requests
  output logic             cpu_normal_req_n,
  output logic             cpu_fast_req_n
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic        hit_main;
  logic        hit_sub1;
  logic        wr_main;
  logic        wr_sub1;
  logic [31:0] main_enable;
  logic [31:0] sub1_enable;
  logic [31:0] rdata_next;

  // the enable registers sit on the fast peripheral bus
  assign hit_main   = bus_addr == isem_pkg::MAIN_ENABLE_ADDR;
  assign hit_sub1   = bus_addr == isem_pkg::SUB1_ENABLE_ADDR;
  assign wr_main    = bus_wr & hit_main;
  assign wr_sub1    = bus_wr & hit_sub1;
  // read mux, unmapped addresses return zero
  assign rdata_next = hit_main ? main_enable :
                      hit_sub1 ? sub1_enable :
                      isem_pkg::UNMAPPED_READ;

  // ----------------------------------------------------------------
  // read data register
  // ----------------------------------------------------------------
  // read data follows the read strobe by one clock
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bus_rdata  <= 32'h0000_0000;
      bus_rvalid <= 1'b0;
    end else begin
      bus_rdata  <= bus_rd ? rdata_next : bus_rdata;
      bus_rvalid <= bus_rd;
    end
  end

  // ----------------------------------------------------------------
  // first sub controller source vector
  // ----------------------------------------------------------------
  logic [31:0] sub1_level;
  logic [31:0] sub1_active;

  // active-low sources are inverted so every bit is active high
  assign sub1_level  = sub1_src_in ^ isem_pkg::SUB1_ACTIVE_LOW_MASK;

  // the software request replaces the pin slot of that position
  always_comb begin
    sub1_active = sub1_level;
    sub1_active[isem_pkg::SUB1_SOFT_IRQ_BIT] =
      soft_irq_trigger[isem_pkg::SOFT_TRIGGER_BIT];
  end

  assign sub1_raw_status = sub1_active;

  // bit-by-bit gating of all sub1 sources
  isem_mask_stage u_sub1 (
    .clk          (core_clk),
    .resetn       (resetn),
    .wr_en        (wr_sub1),
    .wr_data      (bus_wdata),
    .src_active   (sub1_active),
    .fast_sel     (sub1_fast_sel),
    .enable_reg   (sub1_enable),
    .masked_reg   (sub1_masked_status),
    .normal_req_n (sub1_normal_req_n),
    .fast_req_n   (sub1_fast_req_n)
  );

  // ----------------------------------------------------------------
  // main controller source vector
  // ----------------------------------------------------------------
  logic        timer4_slot;
  logic [31:0] main_active;

  // one slot shared by timer 4 and motor pwm
  assign timer4_slot = timer_clock_ctrl_pwm_sel ? motor_pwm_irq : timer4_irq;

  // sub controller outputs are active low and arrive on fixed slots
  always_comb begin
    main_active = main_src_in & ~isem_pkg::MAIN_OWNED_MASK;
    main_active[isem_pkg::MAIN_SUB2_FAST_BIT]   = ~sub2_fast_req_n;
    main_active[isem_pkg::MAIN_SUB1_FAST_BIT]   = ~sub1_fast_req_n;
    main_active[isem_pkg::MAIN_SUB2_NORMAL_BIT] = ~sub2_normal_req_n;
    main_active[isem_pkg::MAIN_SUB1_NORMAL_BIT] = ~sub1_normal_req_n;
    main_active[isem_pkg::MAIN_TIMER4_BIT]      = timer4_slot;
  end

  assign main_raw_status = main_active;

  // main gating drives the processor request lines
  isem_mask_stage u_main (
    .clk          (core_clk),
    .resetn       (resetn),
    .wr_en        (wr_main),
    .wr_data      (bus_wdata),
    .src_active   (main_active),
    .fast_sel     (main_fast_sel),
    .enable_reg   (main_enable),
    .masked_reg   (main_masked_status),
    .normal_req_n (cpu_normal_req_n),
    .fast_req_n   (cpu_fast_req_n)
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  // masked main status tracks raw status and the enables
  property p_main_masked;
    main_masked_status == $past(main_raw_status & main_enable);
  endproperty
  a_main_masked: assert property (p_main_masked)
    else $error("main masked status does not follow enables");

  // a sub1 fast slot in main needs its enable and a low input
  property p_sub1_fast_gate;
    main_masked_status[isem_pkg::MAIN_SUB1_FAST_BIT] |->
      $past(main_enable[isem_pkg::MAIN_SUB1_FAST_BIT]) && $past(!sub1_fast_req_n);
  endproperty
  a_sub1_fast_gate: assert property (p_sub1_fast_gate)
    else $error("sub1 fast slot passed without enable");

  // sub2 normal slot is blocked while its enable is clear
  property p_sub2_normal_gate;
    !main_enable[isem_pkg::MAIN_SUB2_NORMAL_BIT] && !wr_main |=>
      !main_masked_status[isem_pkg::MAIN_SUB2_NORMAL_BIT];
  endproperty
  a_sub2_normal_gate: assert property (p_sub2_normal_gate)
    else $error("sub2 normal slot passed while disabled");

  // shared timer slot follows the selected source
  property p_timer4_select;
    main_enable[isem_pkg::MAIN_TIMER4_BIT] |=>
      main_masked_status[isem_pkg::MAIN_TIMER4_BIT] ==
      $past(timer_clock_ctrl_pwm_sel ? motor_pwm_irq : timer4_irq);
  endproperty
  a_timer4_select: assert property (p_timer4_select)
    else $error("timer4 slot shows wrong source");

  // software slot shows the trigger bit when enabled
  property p_soft_irq;
    sub1_enable[isem_pkg::SUB1_SOFT_IRQ_BIT] |=>
      sub1_masked_status[isem_pkg::SUB1_SOFT_IRQ_BIT] ==
      $past(soft_irq_trigger[isem_pkg::SOFT_TRIGGER_BIT]);
  endproperty
  a_soft_irq: assert property (p_soft_irq)
    else $error("software slot does not follow trigger");

  // active-low inputs request when low
  property p_active_low;
    sub1_enable[isem_pkg::SUB1_I2C1_BIT] && !sub1_src_in[isem_pkg::SUB1_I2C1_BIT] |=>
      sub1_masked_status[isem_pkg::SUB1_I2C1_BIT];
  endproperty
  a_active_low: assert property (p_active_low)
    else $error("active-low source not seen as request");

  // plain high source passes straight through
  property p_ethernet;
    main_masked_status[isem_pkg::MAIN_ETHERNET_BIT] |->
      $past(main_src_in[isem_pkg::MAIN_ETHERNET_BIT]);
  endproperty
  a_ethernet: assert property (p_ethernet)
    else $error("ethernet slot set without source");

  // sub1 top bit follows its pin when enabled
  property p_usb_i2c;
    sub1_masked_status[isem_pkg::SUB1_USB_I2C_BIT] |->
      $past(sub1_src_in[isem_pkg::SUB1_USB_I2C_BIT]) &&
      $past(sub1_enable[isem_pkg::SUB1_USB_I2C_BIT]);
  endproperty
  a_usb_i2c: assert property (p_usb_i2c)
    else $error("usb slot set without cause");

  // clearing every main enable silences both processor requests
  property p_disable_all;
    wr_main && bus_wdata == 32'h0000_0000 ##1 !wr_main |=>
      main_masked_status == 32'h0000_0000 && cpu_normal_req_n && cpu_fast_req_n;
  endproperty
  a_disable_all: assert property (p_disable_all)
    else $error("requests remain after clearing enables");

  // a written value stands in the register from the next clock
  property p_write_main;
    wr_main |=> main_enable == $past(bus_wdata);
  endproperty
  a_write_main: assert property (p_write_main)
    else $error("main enable did not take written value");

  // read returns the enable register one clock later
  property p_read_sub1;
    bus_rd && hit_sub1 && !wr_sub1 |=> bus_rvalid && bus_rdata == sub1_enable;
  endproperty
  a_read_sub1: assert property (p_read_sub1)
    else $error("sub1 read returned wrong value");

  // enables and requests sit cleared while reset is held
  property p_reset_clear;
    disable iff (1'b0)
    !resetn ##1 !resetn |-> main_enable == isem_pkg::ENABLE_RESET &&
      sub1_enable == isem_pkg::ENABLE_RESET && cpu_normal_req_n && cpu_fast_req_n;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("enables or requests not cleared in reset");

  // direct main slots pass only with their pin and enable
  property p_main_direct;
    (main_masked_status & ~isem_pkg::MAIN_OWNED_MASK) ==
      $past(main_src_in & main_enable & ~isem_pkg::MAIN_OWNED_MASK);
  endproperty
  a_main_direct: assert property (p_main_direct)
    else $error("direct main slot does not follow pin and enable");

  // sub1 masked status tracks raw status and the enables
  property p_sub1_masked;
    sub1_masked_status == $past(sub1_raw_status & sub1_enable);
  endproperty
  a_sub1_masked: assert property (p_sub1_masked)
    else $error("sub1 masked status does not follow enables");

  // raw status shows low-going pins as active high
  property p_sub1_raw_pins;
    sub1_raw_status[isem_pkg::SUB1_USB_ATX_BIT] == !sub1_src_in[isem_pkg::SUB1_USB_ATX_BIT] &&
      sub1_raw_status[isem_pkg::SUB1_I2C2_BIT] == !sub1_src_in[isem_pkg::SUB1_I2C2_BIT];
  endproperty
  a_sub1_raw_pins: assert property (p_sub1_raw_pins)
    else $error("active-low pin not inverted in raw status");

  // normal request is the or of enabled slots steered to it
  property p_cpu_normal;
    cpu_normal_req_n == !$past(|(main_raw_status & main_enable & ~main_fast_sel));
  endproperty
  a_cpu_normal: assert property (p_cpu_normal)
    else $error("normal request does not match masked slots");

  // fast request is the or of enabled slots steered to it
  property p_cpu_fast;
    cpu_fast_req_n == !$past(|(main_raw_status & main_enable & main_fast_sel));
  endproperty
  a_cpu_fast: assert property (p_cpu_fast)
    else $error("fast request does not match masked slots");

  // main read returns the enable register one clock later
  property p_read_main;
    bus_rd && hit_main |=> bus_rvalid && bus_rdata == $past(main_enable);
  endproperty
  a_read_main: assert property (p_read_main)
    else $error("main read returned wrong value");

  // unmapped reads still answer, with zero data
  property p_read_unmapped;
    bus_rd && !hit_main && !hit_sub1 |=> bus_rvalid && bus_rdata == isem_pkg::UNMAPPED_READ;
  endproperty
  a_read_unmapped: assert property (p_read_unmapped)
    else $error("unmapped read not answered with zero");

  // a sub1 write stands in the register from the next clock
  property p_write_sub1;
    wr_sub1 |=> sub1_enable == $past(bus_wdata);
  endproperty
  a_write_sub1: assert property (p_write_sub1)
    else $error("sub1 enable did not take written value");

  // without a write the main enables keep their value
  property p_hold_main;
    !wr_main |=> main_enable == $past(main_enable);
  endproperty
  a_hold_main: assert property (p_hold_main)
    else $error("main enable changed without a write");

  // main scenarios
  c_cpu_fast: cover property (!cpu_fast_req_n);
  c_cpu_normal: cover property (!cpu_normal_req_n);
  c_sub1_chain: cover property (!sub1_normal_req_n ##2 !cpu_normal_req_n);
  c_pwm_slot: cover property (timer_clock_ctrl_pwm_sel &&
                              main_masked_status[isem_pkg::MAIN_TIMER4_BIT]);

endmodule : isem_top

// File: tb/isem_src_model.sv
// source model: peripheral lines and second sub controller facing the mask stage
`timescale 1ns/1ps
module isem_src_model (
  // requested activity, active high
  input  wire logic [31:0] sub1_act,
  input  wire logic        sub2_norm_act,
  input  wire logic        sub2_fast_act,
  // lines towards the mask stage
  output logic      [31:0] sub1_src_in,
  output logic      [7:0]  soft_irq_trigger,
  output logic             sub2_normal_req_n,
  output logic             sub2_fast_req_n
);
  // transceiver and both i2c lines pull low to request
  assign sub1_src_in = sub1_act ^ isem_pkg::SUB1_ACTIVE_LOW_MASK;
  // trigger bit 0 raises the software source, message bits stay busy
  assign soft_irq_trigger = {7'h55, sub1_act[isem_pkg::SUB1_SOFT_IRQ_BIT]};
  // second sub controller requests are active low
  assign sub2_normal_req_n = ~sub2_norm_act;
  assign sub2_fast_req_n   = ~sub2_fast_act;
endmodule : isem_src_model

// File: tb/isem_top_tb_top.sv
// self-checking bench for the enable masking stage
`timescale 1ns/1ps
module isem_top_tb_top;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        core_clk, resetn, bus_wr, bus_rd, bus_rvalid, timer4_irq, motor_pwm_irq;
  logic        pwm_sel, sub2_norm_act, sub2_fast_act, sub2_normal_req_n, sub2_fast_req_n;
  logic        sub1_normal_req_n, sub1_fast_req_n, cpu_normal_req_n, cpu_fast_req_n;
  logic [7:0]  soft_irq_trigger;
  logic [31:0] bus_addr, bus_wdata, bus_rdata, main_src_in, main_fast_sel, sub1_fast_sel;
  logic [31:0] sub1_act, sub1_src_in, main_raw_status, main_masked_status;
  logic [31:0] sub1_raw_status, sub1_masked_status;
  int          fails, n_tests, b;
  int          main_bits[10] = '{29, 28, 27, 15, 14, 13, 11, 6, 5, 4};
  int          sub1_bits[23] = '{31, 30, 29, 28, 27, 26, 25, 24, 23, 22, 20, 19, 18, 17,
                                 14, 13, 12, 8, 7, 6, 4, 2, 1};
  // main enable per row, then fast steer, sub2 normal, sub2 fast, expected req_n pair
  logic [31:0] gate_en[6]  = '{32'h0000_0000, 32'h0000_0001, 32'h4000_0000,
                               32'h8000_0002, 32'h8000_0000, 32'h0000_0002};
  logic [4:0]  gate_ctl[6] = '{5'h03, 5'h01, 5'h12, 5'h09, 5'h06, 5'h07};

  // ----------------------------------------------------------------
  // design and far side
  // ----------------------------------------------------------------
  isem_top i_isem_top (
    .core_clk(core_clk), .resetn(resetn), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
    .main_src_in(main_src_in), .timer4_irq(timer4_irq), .motor_pwm_irq(motor_pwm_irq),
    .timer_clock_ctrl_pwm_sel(pwm_sel), .sub2_normal_req_n(sub2_normal_req_n),
    .sub2_fast_req_n(sub2_fast_req_n), .main_fast_sel(main_fast_sel),
    .sub1_src_in(sub1_src_in), .soft_irq_trigger(soft_irq_trigger),
    .sub1_fast_sel(sub1_fast_sel), .main_raw_status(main_raw_status),
    .main_masked_status(main_masked_status), .sub1_raw_status(sub1_raw_status),
    .sub1_masked_status(sub1_masked_status), .sub1_normal_req_n(sub1_normal_req_n),
    .sub1_fast_req_n(sub1_fast_req_n), .cpu_normal_req_n(cpu_normal_req_n),
    .cpu_fast_req_n(cpu_fast_req_n)
  );
  isem_src_model i_isem_src_model (
    .sub1_act(sub1_act), .sub2_norm_act(sub2_norm_act), .sub2_fast_act(sub2_fast_act),
    .sub1_src_in(sub1_src_in), .soft_irq_trigger(soft_irq_trigger),
    .sub2_normal_req_n(sub2_normal_req_n), .sub2_fast_req_n(sub2_fast_req_n)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  // verdict and end of run
  task automatic summarize();
    $display("checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  // compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick

  // one-cycle write strobe
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(negedge core_clk);
    bus_addr  = a;
    bus_wdata = d;
    bus_wr    = 1'b1;
    @(negedge core_clk);
    bus_wr = 1'b0;
  endtask : wr

  // one-cycle read strobe, bounded wait for the answer
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    int i;
    @(negedge core_clk);
    bus_addr = a;
    bus_rd   = 1'b1;
    @(negedge core_clk);
    bus_rd = 1'b0;
    for (i = 0; i < 4 && bus_rvalid !== 1'b1; i++) @(negedge core_clk);
    if (i == 4) begin
      fails++;
      summarize();
    end
    chk(bus_rdata, exp);
  endtask : rd

  // ----------------------------------------------------------------
  // clock and sequence
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  initial begin
    {resetn, bus_wr, bus_rd, timer4_irq, motor_pwm_irq, pwm_sel} = '0;
    {sub2_norm_act, sub2_fast_act, bus_addr, bus_wdata} = '0;
    {main_src_in, main_fast_sel, sub1_fast_sel, sub1_act} = '0;
    fails   = 0;
    n_tests = 0;
    tick(20);
    resetn = 1'b1;
    // reset state, readback, unmapped read; reserved positions written as 0 only in sub1
    chk({cpu_normal_req_n, cpu_fast_req_n}, 2'h3);
    rd(isem_pkg::MAIN_ENABLE_ADDR, isem_pkg::ENABLE_RESET);
    rd(isem_pkg::SUB1_ENABLE_ADDR, isem_pkg::ENABLE_RESET);
    rd(32'h4000_8004, isem_pkg::UNMAPPED_READ);
    wr(isem_pkg::MAIN_ENABLE_ADDR, 32'hA5A5_4A5A);
    wr(isem_pkg::SUB1_ENABLE_ADDR, 32'hFFDE_71D6);
    rd(isem_pkg::MAIN_ENABLE_ADDR, 32'hA5A5_4A5A);
    rd(isem_pkg::SUB1_ENABLE_ADDR, 32'hFFDE_71D6);
    // every direct main source active, one enable at a time
    main_src_in = 32'hFFFF_FFFF;
    wr(isem_pkg::SUB1_ENABLE_ADDR, 32'h0000_0000);
    foreach (main_bits[k]) begin
      b = main_bits[k];
      main_fast_sel = k[0] ? 32'hFFFF_FFFF : 32'h0000_0000;
      wr(isem_pkg::MAIN_ENABLE_ADDR, 32'h0000_0001 << b);
      tick(3);
      chk(main_raw_status, ~isem_pkg::MAIN_OWNED_MASK);
      chk(main_masked_status, 32'h0000_0001 << b);
      chk({cpu_normal_req_n, cpu_fast_req_n}, {k[0], ~k[0]});
    end
    wr(isem_pkg::MAIN_ENABLE_ADDR, 32'h0000_0000);
    tick(3);
    chk(main_masked_status, 32'h0000_0000);
    chk({cpu_normal_req_n, cpu_fast_req_n}, 2'h3);
    // timer4 or motor pwm through main bit 3
    wr(isem_pkg::MAIN_ENABLE_ADDR, 32'h0000_0008);
    for (int i = 0; i < 8; i++) begin
      {pwm_sel, timer4_irq, motor_pwm_irq} = i[2:0];
      tick(3);
      chk(main_masked_status, {28'h0, (i[2] ? i[0] : i[1]), 3'h0});
    end
    // every first sub source active, one enable at a time
    {timer4_irq, motor_pwm_irq, main_src_in} = '0;
    // sub fast slots steer to the fast line, sub normal slots to the normal line
    main_fast_sel = 32'hC000_0000;
    wr(isem_pkg::MAIN_ENABLE_ADDR, 32'h4000_0001);
    sub1_act = 32'hFFFF_FFFF;
    foreach (sub1_bits[k]) begin
      b = sub1_bits[k];
      sub1_fast_sel = k[0] ? 32'hFFFF_FFFF : 32'h0000_0000;
      wr(isem_pkg::SUB1_ENABLE_ADDR, 32'h0000_0001 << b);
      tick(4);
      chk(sub1_raw_status[b], 1'b1);
      chk(sub1_masked_status, 32'h0000_0001 << b);
      chk({sub1_normal_req_n, cpu_normal_req_n, cpu_fast_req_n}, {k[0], k[0], ~k[0]});
      chk({sub1_normal_req_n, sub1_fast_req_n}, {k[0], ~k[0]});
    end
    // idle lines, including the active-low ones, show no raw request
    sub1_act = 32'h0000_0000;
    tick(3);
    chk(sub1_raw_status, 32'h0000_0000);
    // main bits 31/30 and 1/0 gate the sub controller requests
    sub1_act = 32'hFFFF_FFFF;
    wr(isem_pkg::SUB1_ENABLE_ADDR, 32'h8000_0000);
    for (int r = 0; r < 6; r++) begin
      sub1_fast_sel = {32{gate_ctl[r][4]}};
      {sub2_norm_act, sub2_fast_act} = gate_ctl[r][3:2];
      wr(isem_pkg::MAIN_ENABLE_ADDR, gate_en[r]);
      tick(4);
      chk({cpu_normal_req_n, cpu_fast_req_n}, gate_ctl[r][1:0]);
    end
    summarize();
  end
endmodule : isem_top_tb_top
